// >>> logic/wdt_consts.svh
// Constants of the watchdog timer block
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// Register indices on the plain register port
`define WDT_ADDR_W        4
`define WDT_DATA_W        8
`define WDT_IDX_CONTROL   4'h0
`define WDT_IDX_IRQ_STAT  4'h1
`define WDT_IDX_IRQ_MASK  4'h2
`define WDT_IDX_FLAGS     4'h3
`define WDT_IDX_CNT_LO    4'h4
`define WDT_IDX_CNT_MID   4'h5
`define WDT_IDX_CNT_HI    4'h6

// Control register layout and reset value
`define WDT_CTRL_RESET    8'h16
`define WDT_CTRL_WMASK    8'h3F

// Mode configuration encodings
`define WDT_MODE_OFF      2'h0
`define WDT_MODE_SW       2'h1
`define WDT_MODE_AWAKE    2'h2
`define WDT_MODE_ON       2'h3

// Period select limits
`define WDT_PS_W          5
`define WDT_PS_MAX        5'h12
`define WDT_PS_MIN        5'h00
`define WDT_PS_BASE_SH    5'h05

// Counter of oscillator cycles, up to 2^23
`define WDT_CNT_W         23
`define WDT_CNT_ONE       23'h000001
`define WDT_CNT_ZERO      23'h000000

// Sticky event bits
`define WDT_EV_W          2
`define WDT_EV_RESET      0
`define WDT_EV_WAKE       1
`define WDT_EV_ZERO       2'h0

// Flag bits
`define WDT_FLAG_TIMEOUT  0
`define WDT_FLAG_PDOWN    1

`endif

// >>> logic/wdt_pkg.sv
// Types of the watchdog timer block
package wdt_pkg;

  // Control register fields
  typedef struct packed {
    logic [1:0] unused;
    logic [4:0] period_sel;
    logic       sw_enable;
  } wdt_ctrl_type;

  // Power and clock events from the core and reset logic
  typedef struct packed {
    logic clear_instr;
    logic sleep_enter;
    logic sleep_exit;
    logic osc_fail;
    logic ost_running;
    logic irq_pending;
    logic asleep;
  } wdt_evt_type;

  // Watchdog activity state
  typedef enum logic [1:0] {
    WDT_IDLE    = 2'h0,
    WDT_COUNT   = 2'h1,
    WDT_EXPIRED = 2'h3
  } wdt_state_type;

endpackage

// >>> logic/wdt_timer.sv
// Watchdog timer with prescaled oscillator counter and register port
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_timer (
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     low_freq_internal_osc_i,
  input  wire logic [1:0]               wd_mode_cfg_i,
  input  wire wdt_pkg::wdt_evt_type     evt_i,
  input  wire logic [`WDT_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [`WDT_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                     reg_we_i,
  input  wire logic                     reg_re_i,
  output logic      [`WDT_DATA_W-1:0]   reg_rdata_o,
  output logic                          wd_reset_o,
  output logic                          wake_o,
  output logic                          timeout_flag_o,
  output logic                          powerdown_flag_o,
  output logic                          irq_o
);

  wdt_pkg::wdt_ctrl_type              ctrl_ff;
  wdt_pkg::wdt_state_type             state_ff;
  wdt_pkg::wdt_state_type             nxt_state;
  logic [`WDT_CNT_W-1:0]              cnt_ff;
  logic [`WDT_CNT_W-1:0]              nxt_cnt;
  logic [`WDT_EV_W-1:0]               irq_stat_ff;
  logic [`WDT_EV_W-1:0]               irq_mask_ff;
  logic [`WDT_EV_W-1:0]               ev_set;
  logic [`WDT_DATA_W-1:0]             rdata_ff;
  logic                               osc_sync1_ff;
  logic                               osc_sync2_ff;
  logic                               osc_prev_ff;
  logic                               osc_tick;
  logic                               wd_enable;
  logic                               cnt_clear;
  logic                               sleep_taken;
  logic                               expire;
  logic                               wd_reset_ff;
  logic                               wake_ff;
  logic                               timeout_flag_ff;
  logic                               powerdown_flag_ff;
  logic                               wr_ctrl;
  logic                               wr_stat;
  logic                               wr_mask;

  // Last count of the selected interval
  function automatic logic [`WDT_CNT_W-1:0] last_count(
    input logic [`WDT_PS_W-1:0] ps
  );
    logic [`WDT_PS_W-1:0] eff;
    logic [`WDT_PS_W-1:0] sh;
    eff = ps;
    if (ps > `WDT_PS_MAX) begin
      eff = `WDT_PS_MIN;
    end
    sh = eff + `WDT_PS_BASE_SH;
    last_count = (`WDT_CNT_ONE << sh) - `WDT_CNT_ONE;
  endfunction

  // Register index match for a strobe
  function automatic logic hit(
    input logic                   strobe,
    input logic [`WDT_ADDR_W-1:0] addr,
    input logic [`WDT_ADDR_W-1:0] idx
  );
    hit = strobe && (addr == idx);
  endfunction

  assign wr_ctrl = hit(reg_we_i, reg_addr_i, `WDT_IDX_CONTROL);
  assign wr_stat = hit(reg_we_i, reg_addr_i, `WDT_IDX_IRQ_STAT);
  assign wr_mask = hit(reg_we_i, reg_addr_i, `WDT_IDX_IRQ_MASK);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_sync1_ff <= 1'b0;
      osc_sync2_ff <= 1'b0;
    end else begin
      osc_sync1_ff <= low_freq_internal_osc_i;
      osc_sync2_ff <= osc_sync1_ff;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_prev_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_sync2_ff;
    end
  end

  // one tick per oscillator rising edge
  assign osc_tick = osc_sync2_ff && !osc_prev_ff;

  // Mode decode
  always_comb begin
    case (wd_mode_cfg_i)
      `WDT_MODE_ON:    wd_enable = 1'b1;
      `WDT_MODE_AWAKE: wd_enable = !evt_i.asleep;
      `WDT_MODE_SW:    wd_enable = ctrl_ff.sw_enable;
      `WDT_MODE_OFF:   wd_enable = 1'b0;
      default:         wd_enable = 1'b0;
    endcase
  end

  // sleep with pending interrupt does nothing
  assign sleep_taken = evt_i.sleep_enter && !evt_i.irq_pending;

  assign cnt_clear = !wd_enable || evt_i.clear_instr || sleep_taken ||
                     evt_i.sleep_exit || evt_i.osc_fail ||
                     evt_i.ost_running;

  assign expire = osc_tick && !cnt_clear &&
                  (cnt_ff == last_count(ctrl_ff.period_sel));

  // counter only sees clears and ticks
  always_comb begin
    nxt_cnt = cnt_ff;
    if (cnt_clear || expire) begin
      nxt_cnt = `WDT_CNT_ZERO;
    end else if (osc_tick) begin
      nxt_cnt = cnt_ff + `WDT_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= `WDT_CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Activity state for observation
  always_comb begin
    case (state_ff)
      wdt_pkg::WDT_IDLE: begin
        nxt_state = wd_enable ? wdt_pkg::WDT_COUNT : wdt_pkg::WDT_IDLE;
      end
      wdt_pkg::WDT_COUNT: begin
        if (!wd_enable) begin
          nxt_state = wdt_pkg::WDT_IDLE;
        end else if (expire) begin
          nxt_state = wdt_pkg::WDT_EXPIRED;
        end else begin
          nxt_state = wdt_pkg::WDT_COUNT;
        end
      end
      wdt_pkg::WDT_EXPIRED: begin
        nxt_state = wd_enable ? wdt_pkg::WDT_COUNT : wdt_pkg::WDT_IDLE;
      end
      default: nxt_state = wdt_pkg::WDT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= wdt_pkg::WDT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // reset when awake, wake when asleep
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wd_reset_ff <= 1'b0;
      wake_ff     <= 1'b0;
    end else begin
      wd_reset_ff <= expire && !evt_i.asleep;
      wake_ff     <= expire && evt_i.asleep;
    end
  end

  // time-out and power-down flags, set beats clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_flag_ff <= 1'b0;
    end else if (expire) begin
      timeout_flag_ff <= 1'b1;
    end else if (evt_i.clear_instr || sleep_taken) begin
      timeout_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      powerdown_flag_ff <= 1'b0;
    end else if (sleep_taken) begin
      powerdown_flag_ff <= 1'b1;
    end else if (evt_i.clear_instr) begin
      powerdown_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff <= `WDT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= reg_wdata_i & `WDT_CTRL_WMASK;
    end
  end

  // Sticky events, write one to clear, set wins
  always_comb begin
    ev_set                = `WDT_EV_ZERO;
    ev_set[`WDT_EV_RESET] = expire && !evt_i.asleep;
    ev_set[`WDT_EV_WAKE]  = expire && evt_i.asleep;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_ff <= `WDT_EV_ZERO;
    end else if (wr_stat) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[`WDT_EV_W-1:0]) | ev_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev_set;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask_ff <= `WDT_EV_ZERO;
    end else if (wr_mask) begin
      irq_mask_ff <= reg_wdata_i[`WDT_EV_W-1:0];
    end
  end

  // Read data in the cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= '0;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `WDT_IDX_CONTROL:  rdata_ff <= ctrl_ff & `WDT_CTRL_WMASK;
        `WDT_IDX_IRQ_STAT: rdata_ff <= {6'h00, irq_stat_ff};
        `WDT_IDX_IRQ_MASK: rdata_ff <= {6'h00, irq_mask_ff};
        `WDT_IDX_FLAGS:    rdata_ff <= {4'h0, state_ff,
                                        powerdown_flag_ff,
                                        timeout_flag_ff};
        `WDT_IDX_CNT_LO:   rdata_ff <= cnt_ff[7:0];
        `WDT_IDX_CNT_MID:  rdata_ff <= cnt_ff[15:8];
        `WDT_IDX_CNT_HI:   rdata_ff <= {1'b0, cnt_ff[22:16]};
        default:           rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata_o      = rdata_ff;
  assign wd_reset_o       = wd_reset_ff;
  assign wake_o           = wake_ff;
  assign timeout_flag_o   = timeout_flag_ff;
  assign powerdown_flag_o = powerdown_flag_ff;
  assign irq_o            = |(irq_stat_ff & irq_mask_ff);

endmodule

// >>> testbench/wdt_sva.sv
// Port assertions for the watchdog timer
`timescale 1ns/1ps
module wdt_sva (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic [1:0]           wd_mode_cfg_i,
  input  wire wdt_pkg::wdt_evt_type evt_i,
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic                 reg_we_i,
  input  wire logic                 reg_re_i,
  input  wire logic [7:0]           reg_rdata_o,
  input  wire logic                 wd_reset_o,
  input  wire logic                 wake_o,
  input  wire logic                 timeout_flag_o,
  input  wire logic                 irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rst_pulse_a: assert property (wd_reset_o |=> !wd_reset_o)
    else $error("reset pulse too long");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  awake_reset_a: assert property (wd_reset_o |->
    !$past(evt_i.asleep) && timeout_flag_o) else $error("reset while asleep");
  sleep_wake_a: assert property (wake_o |->
    $past(evt_i.asleep) && timeout_flag_o) else $error("wake while awake");
  mode_off_a: assert property ($past(wd_mode_cfg_i) == 2'h0
    |-> !(wd_reset_o || wake_o)) else $error("time-out in mode 00");
  sleep_off_a: assert property ($past(wd_mode_cfg_i == 2'h2
    && evt_i.asleep) |-> !wake_o) else $error("mode 10 woke device");
  fail_clear_a: assert property ($past(evt_i.osc_fail
    || evt_i.ost_running) |-> !(wd_reset_o || wake_o))
    else $error("time-out while held clear");
  ctrl_read_a: assert property ($past(reg_re_i &&
    reg_addr_i == 4'h0) |-> reg_rdata_o[7:6] == 2'h0)
    else $error("control bits 7..6 not zero");
  flag_rise_a: assert property ($rose(timeout_flag_o)
    |-> wd_reset_o || wake_o) else $error("flag without time-out");
  irq_cause_a: assert property ($rose(irq_o) |->
    wd_reset_o || wake_o || $past(reg_we_i)) else $error("stray irq");
endmodule
bind wdt_timer wdt_sva i_sva (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .wd_mode_cfg_i(wd_mode_cfg_i),
  .evt_i(evt_i),
  .reg_addr_i(reg_addr_i),
  .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o),
  .wd_reset_o(wd_reset_o),
  .wake_o(wake_o),
  .timeout_flag_o(timeout_flag_o),
  .irq_o(irq_o)
);

// >>> testbench/wdt_core_model.sv
// Core, sleep controller and slow oscillator model
`timescale 1ns/1ps
module wdt_core_model (
  input  wire logic           clk_i,
  input  wire logic           resetn_i,
  input  wire logic           clr_req_i,
  input  wire logic           sleep_req_i,
  input  wire logic           fail_i,
  input  wire logic           wake_i,
  input  wire logic           ost_i,
  input  wire logic           pend_i,
  output logic                osc_o,
  output wdt_pkg::wdt_evt_type evt_o
);
  logic [1:0] div_ff;
  logic       asleep_ff, enter_ff, exit_ff, clr_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= 2'h0;
      osc_o  <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) osc_o <= ~osc_o;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      asleep_ff <= 1'b0;
      enter_ff  <= 1'b0;
      exit_ff   <= 1'b0;
      clr_ff    <= 1'b0;
    end else begin
      clr_ff    <= clr_req_i;
      // pending interrupt makes sleep a no-op
      enter_ff  <= sleep_req_i & ~asleep_ff & ~pend_i;
      exit_ff   <= wake_i & asleep_ff;
      if (sleep_req_i & ~pend_i) asleep_ff <= 1'b1;
      else if (wake_i) asleep_ff <= 1'b0;
    end
  end
  assign evt_o = {clr_ff, enter_ff, exit_ff, fail_i, ost_i, pend_i, asleep_ff};
endmodule

// >>> testbench/watchdog_timer_block_test.sv
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
module watchdog_timer_block_test;
  logic                 clk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic [1:0]           mode = 2'h0;
  logic [3:0]           addr = 4'h0;
  logic [7:0]           wdata = 8'h00;
  logic                 we = 1'b0, re = 1'b0, clr = 1'b0, slp = 1'b0;
  logic                 fail = 1'b0, wreq = 1'b0;
  logic                 osc_startup_timer = 1'b0, pend = 1'b0;
  logic                 osc, rst_o, wake, tflag, pflag, irq;
  wdt_pkg::wdt_evt_type evt;
  logic [7:0]           rdata;
  logic [15:0]          tc [11];
  int                   n_fail = 0, compares = 0, cyc = 0, n, ex;
  wdt_timer i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .low_freq_internal_osc_i(osc),
    .wd_mode_cfg_i(mode), .evt_i(evt), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .wd_reset_o(rst_o), .wake_o(wake),
    .timeout_flag_o(tflag), .powerdown_flag_o(pflag), .irq_o(irq));
  wdt_core_model i_core (
    .clk_i(clk_i), .resetn_i(resetn_i), .clr_req_i(clr),
    .sleep_req_i(slp), .fail_i(fail), .wake_i(wake | wreq),
    .ost_i(osc_startup_timer), .pend_i(pend),
    .osc_o(osc), .evt_o(evt));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk_i);
    we    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_i);
    re   <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Clear instruction, or sleep entry when s is set
  task automatic kick(input logic s);
    @(posedge clk_i);
    if (s) slp <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    clr <= 1'b0;
  endtask
  task automatic meas(input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (!(rst_o || wake) && n < lim);
  endtask
  initial begin
    // Row: mode, sleep, fail, ticks/32, control value
    tc[0]  = {2'h3, 2'h0, 4'h1, 8'h00};
    tc[1]  = {2'h3, 2'h0, 4'h2, 8'h02};
    tc[2]  = {2'h3, 2'h0, 4'h1, 8'h26};
    tc[3]  = {2'h3, 2'h0, 4'h1, 8'h3E};
    tc[4]  = {2'h0, 2'h0, 4'h0, 8'h01};
    tc[5]  = {2'h1, 2'h0, 4'h0, 8'h00};
    tc[6]  = {2'h1, 2'h0, 4'h1, 8'h01};
    tc[7]  = {2'h2, 2'h2, 4'h0, 8'h01};
    tc[8]  = {2'h2, 2'h0, 4'h1, 8'h00};
    tc[9]  = {2'h3, 2'h2, 4'h1, 8'h00};
    tc[10] = {2'h3, 2'h1, 4'h0, 8'h00};
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(4'h0, 8'h16);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h3F);
    rd(4'hF, 8'h00);
    wr(4'h2, 8'h03);
    $display("register test done");
    foreach (tc[i]) begin
      wr(4'h1, 8'h03);
      wr(4'h0, tc[i][7:0]);
      mode <= tc[i][15:14];
      fail <= tc[i][12];
      kick(tc[i][13]);
      meas(700);
      ex = 256 * tc[i][11:8];
      chk({7'h0, ex == 0 ? n == 700 : n > ex - 16 && n < ex + 16}, 8'h01);
      if (ex != 0) begin
        chk({6'h0, wake, rst_o}, tc[i][13] ? 8'h02 : 8'h01);
        chk({6'h0, pflag, tflag}, {6'h0, tc[i][13], 1'b1});
        chk({7'h0, irq}, 8'h01);
      end
      mode <= 2'h0;
      fail <= 1'b0;
      wreq <= 1'b1;
      kick(1'b0);
      wreq <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk({6'h0, pflag, tflag}, 8'h00);
      $display("case %0d done", i);
    end
    wr(4'h1, 8'h03);
    mode <= 2'h3;
    osc_startup_timer <= 1'b1;
    kick(1'b0);
    meas(700);
    chk({7'h0, n == 700}, 8'h01);
    osc_startup_timer <= 1'b0;
    meas(700);
    chk({7'h0, n > 240 && n < 272}, 8'h01);
    kick(1'b0);
    repeat (100) @(posedge clk_i);
    pend <= 1'b1;
    kick(1'b1);
    repeat (2) @(posedge clk_i);
    pend <= 1'b0;
    meas(700);
    chk({6'h0, pflag, n < 200 && rst_o}, 8'h01);
    $display("start-up and pending sleep test done");
    repeat (4) begin
      kick(1'b0);
      meas(160);
      chk({7'h0, n == 160}, 8'h01);
    end
    wr(4'h2, 8'h00);
    meas(700);
    mode <= 2'h0;
    chk({7'h0, irq, rst_o}, 8'h01);
    wr(4'h2, 8'h01);
    #1 chk({7'h0, irq}, 8'h01);
    wr(4'h1, 8'h01);
    #1 chk({7'h0, irq}, 8'h00);
    $display("clear and interrupt test done");
    give_verdict();
  end
endmodule
